// ### core/lcdrf_defs.vh
// constants for the lcd ram fill host port
`ifndef LCDRF_DEFS_VH
`define LCDRF_DEFS_VH

// slave address: six fixed bits, then the strap level, then direction
`define LCDRF_ADDR_PREFIX 6'h1C
`define LCDRF_DIR_READ 1'b1

// control byte field positions
`define LCDRF_CTRL_MORE_BIT 7
`define LCDRF_CTRL_KIND_BIT 6

// multiplex drive mode codes
`define LCDRF_MODE_STATIC 3'h0
`define LCDRF_MODE_MUX2 3'h1
`define LCDRF_MODE_MUX4 3'h2
`define LCDRF_MODE_MUX6 3'h3
`define LCDRF_MODE_MUX8 3'h4

// rows per column used by each mode
`define LCDRF_ROWS_STATIC 4'h1
`define LCDRF_ROWS_MUX2 4'h2
`define LCDRF_ROWS_MUX4 4'h4
`define LCDRF_ROWS_MUX6 4'h6
`define LCDRF_ROWS_MUX8 4'h8

// column counts and bank geometry
`define LCDRF_COLS_NORMAL 6'h2C
`define LCDRF_COLS_MUX6 6'h2E
`define LCDRF_BANK1_ROW 3'h4
`define LCDRF_BANK_SHIFT 3'h4

// reset values
`define LCDRF_RESET_COL 6'h00
`define LCDRF_RESET_ROW 3'h0

`endif

// ### core/lcdrf_mem.v
// display ram: columns of eight row bits, single bit write, registered read
`default_nettype none

module lcdrf_mem #(
    parameter DEPTH = 46,
    parameter AW = 6,
    parameter WIDTH = 8,
    parameter RW = 3
) (
    // clock and reset
    input wire sys_clk,
    input wire arst_n,
    // bit write port
    input wire wr_en,
    input wire [AW-1:0] wr_col,
    input wire [RW-1:0] wr_row,
    input wire wr_bit,
    // column read port
    input wire [AW-1:0] rd_col,
    output reg [WIDTH-1:0] rd_data
);

    reg [WIDTH-1:0] cells [0:DEPTH-1];

    // write one element at a time, the array itself needs no reset
    always @(posedge sys_clk) begin
        if (wr_en) begin
            cells[wr_col][wr_row] <= wr_bit;
        end
    end

    // read data leaves through a register
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= {WIDTH{1'b0}};
        end else if ({{(32-AW){1'b0}}, rd_col} < DEPTH) begin
            rd_data <= cells[rd_col];
        end else begin
            rd_data <= {WIDTH{1'b0}};
        end
    end

endmodule

`default_nettype wire

// ### core/lcdrf_host_port.v
// i2c slave write path, control byte parser and display ram filler
`include "lcdrf_defs.vh"
`default_nettype none

// Behaviour
// - static: byte bits go to eight successive columns of row 0
// - static: six bytes fill a row, last four bits fall off
// - static with input bank 1: bits land in row 4
// - 1:2: byte fills four columns over two rows, 11 bytes fill all
// - 1:2 with input bank 1: data lands in rows 4 and 5
// - 1:4: byte fills two columns four rows deep, 22 bytes fill all
// - 1:4 with input bank 1: data lands in rows 4 to 7
// - 1:6: six rows by 46 columns, spare bits wrap to next column
// - 1:6: 35 bytes fill ram, low four bits of last dropped
// - 1:6: first byte of each data run starts at row 0
// - 1:8: each byte fills all eight rows of one column, 44 bytes
// - two banks exist only in static, 1:2 and 1:4 modes
// - input bank choice picks the written bank, independent of shown bank
// - shown bank choice picks the displayed bank, independent of input bank
// - control byte bit 7 says whether another control byte follows
// - control byte bit 6 selects command or display bytes, rest ignored
// - answer address 011100 plus strap level in bit 1
// - address lsb selects write or read; read gives temperature byte
// - acknowledge every byte once addressed, data low through ack clock
// - slave only; data line driven only for ack and readout
// - write pointer stops at row end, later bytes discarded until reload
module lcdrf_host_port (
    // clock and reset
    input wire sys_clk,
    input wire arst_n,
    // i2c pins, open drain
    input wire scl_in,
    output reg scl_out,
    output reg scl_out_en,
    input wire sda_in,
    output reg sda_out,
    output reg sda_out_en,
    input wire address_strap_pin,
    // configuration from the command decoder
    input wire [2:0] mux_mode,
    input wire input_bank_choice,
    input wire shown_bank_choice,
    input wire ptr_load,
    input wire [5:0] ptr_col,
    input wire [7:0] temp_byte,
    // command bytes towards the decoder
    output reg cmd_valid,
    output reg [7:0] cmd_byte,
    input wire cmd_ready,
    // display readout
    input wire [5:0] disp_col,
    output reg [7:0] disp_data
);

    localparam ST_IDLE = 3'h0;
    localparam ST_RX = 3'h1;
    localparam ST_ACK = 3'h2;
    localparam ST_TX = 3'h3;
    localparam ST_MACK = 3'h4;

    localparam K_ADDR = 2'h0;
    localparam K_CTRL = 2'h1;
    localparam K_CMD = 2'h2;
    localparam K_DISP = 2'h3;

    // rows that one column holds in a mode
    function [3:0] rows_of;
        input [2:0] mode;
        begin
            case (mode)
                `LCDRF_MODE_STATIC: rows_of = `LCDRF_ROWS_STATIC;
                `LCDRF_MODE_MUX2: rows_of = `LCDRF_ROWS_MUX2;
                `LCDRF_MODE_MUX4: rows_of = `LCDRF_ROWS_MUX4;
                `LCDRF_MODE_MUX6: rows_of = `LCDRF_ROWS_MUX6;
                default: rows_of = `LCDRF_ROWS_MUX8;
            endcase
        end
    endfunction

    // bank switching only exists in the three smallest modes
    function banked;
        input [2:0] mode;
        begin
            banked = (mode == `LCDRF_MODE_STATIC) || (mode == `LCDRF_MODE_MUX2) ||
                     (mode == `LCDRF_MODE_MUX4);
        end
    endfunction

    // pin synchronisers
    reg scl_m, scl_s, scl_d;
    reg sda_m, sda_s, sda_d;
    reg strap_m, strap_s;

    // bus state
    reg [2:0] state;
    reg [1:0] kind;
    reg [3:0] bit_cnt;
    reg [7:0] shreg;
    reg more;
    reg is_read;
    reg mack_ok;

    // command buffer
    reg [7:0] cmd_next;
    reg [1:0] fifo_cnt;

    // placement
    reg [5:0] col;
    reg [2:0] sub;
    reg [7:0] place_sh;
    reg [3:0] place_cnt;

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
    wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;
    wire byte_end = (state == ST_RX) && (bit_cnt == 4'h8) && (scl_fall || scl_out_en);
    wire addr_hit = (shreg[7:1] == {`LCDRF_ADDR_PREFIX, strap_s});
    wire fifo_full = (fifo_cnt == 2'h2);
    wire cmd_pop = cmd_valid & cmd_ready;
    wire cmd_push = byte_end && (kind == K_CMD) && !fifo_full;
    wire disp_take = byte_end && (kind == K_DISP);
    wire ctrl_take = byte_end && (kind == K_CTRL);
    wire [3:0] rows = rows_of(mux_mode);
    wire [5:0] col_limit = (mux_mode == `LCDRF_MODE_MUX6) ? `LCDRF_COLS_MUX6 : `LCDRF_COLS_NORMAL;
    wire [2:0] row_base = (banked(mux_mode) && input_bank_choice) ? `LCDRF_BANK1_ROW : `LCDRF_RESET_ROW;
    wire place_on = (place_cnt != 4'h0);
    wire wr_en = place_on && (col < col_limit);
    wire [2:0] wr_row = row_base + sub;
    wire [7:0] mem_q;

    // two flip-flops on every pin input
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            strap_m <= 1'b0;
            strap_s <= 1'b0;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
            strap_m <= address_strap_pin;
            strap_s <= strap_m;
        end
    end

    // i2c slave: receive, acknowledge, stretch on a full buffer, transmit readout
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            kind <= K_ADDR;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            more <= 1'b0;
            is_read <= 1'b0;
            mack_ok <= 1'b0;
            sda_out <= 1'b0;
            sda_out_en <= 1'b0;
            scl_out <= 1'b0;
            scl_out_en <= 1'b0;
        end else if (bus_start) begin
            state <= ST_RX;
            kind <= K_ADDR;
            bit_cnt <= 4'h0;
            sda_out_en <= 1'b0;
            scl_out_en <= 1'b0;
        end else if (bus_stop) begin
            state <= ST_IDLE;
            sda_out_en <= 1'b0;
            scl_out_en <= 1'b0;
        end else begin
            case (state)
                ST_RX: begin
                    if (scl_rise && bit_cnt != 4'h8) begin
                        shreg <= {shreg[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_end) begin
                        bit_cnt <= 4'h0;
                        state <= ST_ACK;
                        sda_out_en <= 1'b1;
                        case (kind)
                            K_ADDR: begin
                                if (addr_hit) begin
                                    is_read <= shreg[0];
                                    kind <= K_CTRL;
                                end else begin
                                    state <= ST_IDLE;
                                    sda_out_en <= 1'b0;
                                end
                            end
                            K_CTRL: begin
                                more <= shreg[`LCDRF_CTRL_MORE_BIT];
                                kind <= shreg[`LCDRF_CTRL_KIND_BIT] ? K_DISP : K_CMD;
                            end
                            K_CMD: begin
                                if (fifo_full) begin
                                    state <= ST_RX;
                                    bit_cnt <= 4'h8;
                                    sda_out_en <= 1'b0;
                                    scl_out_en <= 1'b1; // hold the clock low until room
                                end else if (more) begin
                                    kind <= K_CTRL;
                                end
                            end
                            default: begin
                                if (more) begin
                                    kind <= K_CTRL;
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    scl_out_en <= 1'b0; // clock freed a cycle after the data line is low
                    if (scl_fall) begin
                        if (is_read && kind == K_CTRL) begin
                            state <= ST_TX;
                            shreg <= {temp_byte[6:0], 1'b0};
                            sda_out_en <= ~temp_byte[7];
                        end else begin
                            state <= ST_RX;
                            sda_out_en <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'h7) begin
                            bit_cnt <= 4'h0;
                            sda_out_en <= 1'b0;
                            state <= ST_MACK;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                            sda_out_en <= ~shreg[7];
                            shreg <= {shreg[6:0], 1'b0};
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        mack_ok <= ~sda_s;
                    end else if (scl_fall) begin
                        if (mack_ok) begin
                            state <= ST_TX;
                            shreg <= {temp_byte[6:0], 1'b0};
                            sda_out_en <= ~temp_byte[7];
                        end else begin
                            state <= ST_IDLE; // line left released
                        end
                    end
                end
                default: begin
                    sda_out_en <= 1'b0;
                    scl_out_en <= 1'b0;
                end
            endcase
        end
    end

    // two-entry command buffer, head held in the output register
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fifo_cnt <= 2'h0;
            cmd_valid <= 1'b0;
            cmd_byte <= 8'h00;
            cmd_next <= 8'h00;
        end else begin
            case ({cmd_push, cmd_pop})
                2'b10: begin
                    fifo_cnt <= fifo_cnt + 2'h1;
                    cmd_valid <= 1'b1;
                    if (fifo_cnt == 2'h0) begin
                        cmd_byte <= shreg;
                    end else begin
                        cmd_next <= shreg;
                    end
                end
                2'b01: begin
                    fifo_cnt <= fifo_cnt - 2'h1;
                    cmd_valid <= (fifo_cnt == 2'h2);
                    cmd_byte <= cmd_next;
                end
                2'b11: begin
                    if (fifo_cnt == 2'h1) begin
                        cmd_byte <= shreg;
                    end else begin
                        cmd_byte <= cmd_next;
                        cmd_next <= shreg;
                    end
                end
                default: begin
                    cmd_valid <= (fifo_cnt != 2'h0);
                end
            endcase
        end
    end

    // bit serial placement of display bytes, msb first
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            col <= `LCDRF_RESET_COL;
            sub <= `LCDRF_RESET_ROW;
            place_sh <= 8'h00;
            place_cnt <= 4'h0;
        end else if (ptr_load) begin
            col <= ptr_col;
            sub <= `LCDRF_RESET_ROW;
            place_cnt <= 4'h0;
        end else if (ctrl_take) begin
            sub <= `LCDRF_RESET_ROW;
        end else if (disp_take) begin
            place_sh <= shreg;
            place_cnt <= 4'h8;
        end else if (place_on) begin
            place_sh <= {place_sh[6:0], 1'b0};
            place_cnt <= place_cnt - 4'h1;
            if (col < col_limit) begin
                if ({1'b0, sub} == rows - 4'h1) begin
                    sub <= `LCDRF_RESET_ROW;
                    col <= col + 6'h01;
                end else begin
                    sub <= sub + 3'h1;
                end
            end
            // past the row end the pointer stays put and bits are dropped
        end
    end

    // displayed bank mapped onto the low rows
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            disp_data <= 8'h00;
        end else if (banked(mux_mode) && shown_bank_choice) begin
            disp_data <= mem_q >> `LCDRF_BANK_SHIFT;
        end else begin
            disp_data <= mem_q;
        end
    end

    lcdrf_mem #(
        .DEPTH(46),
        .AW(6),
        .WIDTH(8),
        .RW(3)
    ) u_mem (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wr_en(wr_en),
        .wr_col(col),
        .wr_row(wr_row),
        .wr_bit(place_sh[7]),
        .rd_col(disp_col),
        .rd_data(mem_q)
    );

endmodule

`default_nettype wire

// ### verification/lcdrf_host_port_props.sv
// concurrent checks on the host port pins and command buffer
`default_nettype none
module lcdrf_host_port_props (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // i2c pins
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_out_en,
    input wire logic sda_out,
    input wire logic sda_out_en,
    // command buffer
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // open-drain pins only ever pull low
    a_scl_never_high: assert property (scl_out == 1'b0)
        else $error("scl driven high");
    a_sda_never_high: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    // a low data level holds through the whole clock high phase
    a_ack_hold_high: assert property (sda_out_en && scl_in |=> sda_out_en)
        else $error("data released while clock high");
    a_sda_moves_low: assert property ($changed(sda_out_en) |-> !$past(scl_in))
        else $error("data changed while clock high");
    a_ack_before_release: assert property ($fell(scl_out_en) |-> sda_out_en && $past(sda_out_en))
        else $error("clock freed before acknowledge was set up");
    // command bytes wait unchanged until taken
    a_cmd_holds: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_byte))
        else $error("command byte dropped or changed");
    // stretching only as back-pressure, only in the low phase, and briefly
    a_stretch_cause: assert property ($rose(scl_out_en) |-> cmd_valid && !cmd_ready)
        else $error("stretch without full buffer");
    a_stretch_low: assert property ($rose(scl_out_en) |-> !$past(scl_in))
        else $error("stretch began in clock high");
    a_stretch_ends: assert property (scl_out_en && cmd_ready |-> ##[1:16] !scl_out_en)
        else $error("stretch kept after room");
    // main scenarios
    c_stretch: cover property ($rose(scl_out_en));
    c_pop: cover property (cmd_valid && cmd_ready);
    c_ack: cover property (sda_out_en && scl_in);
endmodule
`default_nettype wire

// ### verification/lcdrf_i2c_master.sv
// open-drain i2c master model driving the host port
`default_nettype none
module lcdrf_i2c_master (
    // resolved bus levels
    input wire logic scl_w,
    input wire logic sda_w,
    // pull-downs, high pulls the line low
    output logic scl_low,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime H = 62.5;
    // bus idles released
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // one clock pulse; waits out any stretch by the slave
    task automatic pulse(input logic lo, output logic seen);
        #(H / 2);
        sda_low = lo;
        #(H / 2);
        scl_low = 1'b0;
        wait (scl_w === 1'b1);
        #H;
        seen = sda_w;
        scl_low = 1'b1;
    endtask
    // start or repeated start
    task automatic start();
        #(H / 2);
        sda_low = 1'b0;
        #(H / 2);
        scl_low = 1'b0;
        wait (scl_w === 1'b1);
        #(H / 2);
        sda_low = 1'b1;
        #(H / 2);
        scl_low = 1'b1;
    endtask
    task automatic stop();
        #(H / 2);
        sda_low = 1'b1;
        #(H / 2);
        scl_low = 1'b0;
        wait (scl_w === 1'b1);
        #(H / 2);
        sda_low = 1'b0;
        #H;
    endtask
    // byte out msb first, then the slave's acknowledge slot
    task automatic wr(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(!b[i], s);
        end
        pulse(1'b0, s);
        ack = !s;
    endtask
    // byte in; acknowledge all but the last
    task automatic rd(input logic give_ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b0, s);
            d[i] = s;
        end
        pulse(give_ack, s);
    endtask
endmodule
`default_nettype wire

// ### verification/test_lcdrf_host_port.sv
// self-checking bench for the lcd ram fill host port
`default_nettype none
module test_lcdrf_host_port;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [2:0] m;
        logic ib;
        logic sb;
        logic [5:0] p;
        logic [7:0] d;
        logic [5:0] c;
        logic [7:0] k;
        logic [7:0] e;
    } lcdrf_row_t;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic scl_low, sda_low, ptr_load, input_bank_choice, shown_bank_choice, cmd_ready, address_strap_pin, a;
    logic [2:0] mux_mode;
    logic [5:0] ptr_col, disp_col;
    logic [7:0] temp_byte, d;
    wire logic scl_out, scl_out_en, sda_out, sda_out_en, cmd_valid;
    wire logic [7:0] cmd_byte, disp_data;
    wire logic scl_w = !(scl_low || scl_out_en && !scl_out);
    wire logic sda_w = !(sda_low || sda_out_en && !sda_out);
    logic [7:0] got[$];
    logic [7:0] want_cmd [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    int failures = 0;
    int comparisons = 0;
    // mode, input bank, shown bank, pointer, byte, column, mask, expected
    lcdrf_row_t rows [10] = '{
        '{3'h0, 1'b0, 1'b0, 6'h00, 8'hA5, 6'h02, 8'h01, 8'h01},
        '{3'h0, 1'b1, 1'b1, 6'h00, 8'h5A, 6'h02, 8'h01, 8'h00},
        '{3'h0, 1'b1, 1'b0, 6'h00, 8'h5A, 6'h02, 8'h01, 8'h01},
        '{3'h1, 1'b0, 1'b0, 6'h04, 8'h96, 6'h05, 8'h03, 8'h02},
        '{3'h1, 1'b1, 1'b1, 6'h04, 8'h69, 6'h05, 8'h03, 8'h01},
        '{3'h2, 1'b0, 1'b0, 6'h0A, 8'hE1, 6'h0B, 8'h0F, 8'h08},
        '{3'h2, 1'b1, 1'b1, 6'h0A, 8'h1E, 6'h0A, 8'h0F, 8'h08},
        '{3'h4, 1'b1, 1'b1, 6'h14, 8'hB4, 6'h14, 8'hFF, 8'h2D},
        '{3'h3, 1'b1, 1'b1, 6'h1E, 8'hC9, 6'h1E, 8'h3F, 8'h13},
        '{3'h3, 1'b0, 1'b0, 6'h1E, 8'hC9, 6'h1F, 8'h03, 8'h02}
    };
    always #2.5 sys_clk = ~sys_clk;
    lcdrf_host_port DUT (.sys_clk(sys_clk), .arst_n(arst_n), .scl_in(scl_w), .scl_out(scl_out),
        .scl_out_en(scl_out_en), .sda_in(sda_w), .sda_out(sda_out), .sda_out_en(sda_out_en),
        .address_strap_pin(address_strap_pin), .mux_mode(mux_mode), .input_bank_choice(input_bank_choice),
        .shown_bank_choice(shown_bank_choice), .ptr_load(ptr_load), .ptr_col(ptr_col), .temp_byte(temp_byte),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .disp_col(disp_col),
        .disp_data(disp_data));
    lcdrf_i2c_master mst (.scl_w(scl_w), .sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low));
    // collect command bytes as they are taken
    always @(posedge sys_clk) begin
        if (cmd_valid === 1'b1 && cmd_ready === 1'b1) got.push_back(cmd_byte);
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            failures++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // set mode and banks, then load the write pointer
    task automatic setup(input logic [2:0] m, input logic ib, input logic sb, input logic [5:0] p);
        @(negedge sys_clk);
        mux_mode = m;
        input_bank_choice = ib;
        shown_bank_choice = sb;
        ptr_col = p;
        ptr_load = 1'b1;
        @(negedge sys_clk);
        ptr_load = 1'b0;
    endtask
    // one write access: address, then control and payload in one unbroken run
    task automatic frame(input logic [7:0] q[]);
        logic ak;
        mst.start();
        mst.wr(8'h72, ak);
        check({7'h00, ak}, 8'h01);
        foreach (q[i]) begin
            mst.wr(q[i], ak);
            check({7'h00, ak}, 8'h01);
        end
        mst.stop();
    endtask
    task automatic probe(input logic [7:0] adr, input logic want);
        logic ak;
        mst.start();
        mst.wr(adr, ak);
        mst.stop();
        check({7'h00, ak}, {7'h00, want});
    endtask
    task automatic look(input logic [5:0] c, input logic [7:0] k, input logic [7:0] e);
        @(negedge sys_clk);
        disp_col = c;
        repeat (3) @(negedge sys_clk);
        check(disp_data & k, e);
    endtask
    initial begin
        address_strap_pin = 1'b1;
        mux_mode = 3'h0;
        input_bank_choice = 1'b0;
        shown_bank_choice = 1'b0;
        ptr_load = 1'b0;
        ptr_col = 6'h00;
        temp_byte = 8'h5C;
        cmd_ready = 1'b1;
        disp_col = 6'h00;
        repeat (4) @(negedge sys_clk);
        check({5'h00, cmd_valid, sda_out_en, scl_out_en}, 8'h00);
        arst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        foreach (rows[i]) begin
            setup(rows[i].m, rows[i].ib, rows[i].sb, rows[i].p);
            frame('{8'h40, rows[i].d});
            look(rows[i].c, rows[i].k, rows[i].e);
        end
        // a new access restarts the 1:6 column at row 0
        frame('{8'h7F, 8'h80});
        look(6'h1F, 8'h3F, 8'h01);
        // static row end: spare bits and later bytes are dropped, no wrap
        setup(3'h0, 1'b0, 1'b0, 6'h00);
        frame('{8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1F, 8'hFF});
        look(6'h2B, 8'h01, 8'h01);
        look(6'h00, 8'h01, 8'h00);
        // strap level decides the answered address
        probe(8'h70, 1'b0);
        address_strap_pin = 1'b0;
        repeat (4) @(negedge sys_clk);
        probe(8'h70, 1'b1);
        probe(8'h72, 1'b0);
        address_strap_pin = 1'b1;
        repeat (4) @(negedge sys_clk);
        // read returns the temperature byte until the master declines
        mst.start();
        mst.wr(8'h73, a);
        check({7'h00, a}, 8'h01);
        mst.rd(1'b1, d);
        check(d, 8'h5C);
        mst.rd(1'b0, d);
        check(d, 8'h5C);
        mst.stop();
        // full command buffer stretches the clock, then drains in order
        @(negedge sys_clk);
        cmd_ready = 1'b0;
        fork
            frame('{8'hBF, 8'h11, 8'hBF, 8'h22, 8'h3F, 8'h33, 8'h44});
            begin
                wait (scl_out_en === 1'b1);
                @(negedge sys_clk);
                check({7'h00, scl_out_en}, 8'h01);
                repeat (40) @(negedge sys_clk);
                cmd_ready = 1'b1;
            end
        join
        setup(3'h4, 1'b0, 1'b0, 6'h05);
        frame('{8'h80, 8'h55, 8'h40, 8'hB4});
        look(6'h05, 8'hFF, 8'h2D);
        check(8'(got.size()), 8'h05);
        foreach (want_cmd[i]) check(got[i], want_cmd[i]);
        // reset after the access, with a command still waiting, empties the command buffer
        cmd_ready = 1'b0;
        frame('{8'h00, 8'h66});
        check({7'h00, cmd_valid}, 8'h01);
        @(negedge sys_clk);
        arst_n = 1'b0;
        @(negedge sys_clk);
        check({5'h00, cmd_valid, sda_out_en, scl_out_en}, 8'h00);
        arst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        check({5'h00, cmd_valid, sda_out_en, scl_out_en}, 8'h00);
        // a command sent after the reset is the head, the old one is gone
        frame('{8'h00, 8'h77});
        check(cmd_byte, 8'h77);
        report_and_stop();
    end
    // watchdog against a hung bus
    initial begin
        #400000;
        failures++;
        report_and_stop();
    end
endmodule
bind lcdrf_host_port lcdrf_host_port_props u_props (.sys_clk(sys_clk), .arst_n(arst_n), .scl_in(scl_in),
    .scl_out(scl_out), .scl_out_en(scl_out_en), .sda_out(sda_out), .sda_out_en(sda_out_en),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready));
`default_nettype wire
